/* hw/pss_pkg.sv */
// package for the power state sequencer: states, wake steps, rail bundle, timing
// assumes a 125 MHz core clock that stands for the crystal-derived clock when active
package pss_pkg;

	localparam int CLK_MHZ = 125;

	function automatic int ns2cyc(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	// wake step and enable filter durations in ns, plain defaults
	localparam int T_REG_NS = 2000;
	localparam int T_PWR_NS = 4000;
	localparam int T_XTAL_NS = 24000;
	localparam int T_PLL_NS = 8000;
	localparam int T_CORE_NS = 16000;
	localparam int T_BB_FULL_NS = 30000;
	localparam int T_BB_WARM_NS = 3000;
	localparam int T_RF_FULL_NS = 32000;
	localparam int T_RF_WARM_NS = 4000;
	localparam int T_FILT_NS = 128;

	localparam logic [11:0] C_REG = 12'(ns2cyc(T_REG_NS));
	localparam logic [11:0] C_PWR = 12'(ns2cyc(T_PWR_NS));
	localparam logic [11:0] C_XTAL = 12'(ns2cyc(T_XTAL_NS));
	localparam logic [11:0] C_PLL = 12'(ns2cyc(T_PLL_NS));
	localparam logic [11:0] C_CORE = 12'(ns2cyc(T_CORE_NS));
	localparam logic [11:0] C_BB_FULL = 12'(ns2cyc(T_BB_FULL_NS));
	localparam logic [11:0] C_BB_WARM = 12'(ns2cyc(T_BB_WARM_NS));
	localparam logic [11:0] C_RF_FULL = 12'(ns2cyc(T_RF_FULL_NS));
	localparam logic [11:0] C_RF_WARM = 12'(ns2cyc(T_RF_WARM_NS));
	localparam logic [4:0] C_FILT = 5'(ns2cyc(T_FILT_NS));

	localparam logic signed [7:0] TRIM_MAX_PPM = 8'sh14;
	localparam logic [3:0] CAL_TICKS = 4'h8;
	localparam logic [15:0] RESET_WAKE = 16'h0000;

	typedef enum logic [2:0] {
		PSS_SHUTDOWN = 3'h1,
		PSS_SLEEP = 3'h2,
		PSS_ACTIVE = 3'h4
	} pss_power_t;

	typedef enum logic [7:0] {
		STEP_REG = 8'h01,
		STEP_PWR = 8'h02,
		STEP_XTAL = 8'h04,
		STEP_PLL = 8'h08,
		STEP_CORE = 8'h10,
		STEP_BB = 8'h20,
		STEP_RF = 8'h40,
		STEP_DONE = 8'h80
	} pss_step_t;

	typedef enum logic [2:0] {
		SUB_IDLE = 3'h1,
		SUB_RX = 3'h2,
		SUB_TX = 3'h4
	} pss_sub_t;

	typedef struct packed {
		logic reg_high;
		logic logic_on;
		logic xtal_on;
		logic pll_on;
		logic core_boot;
		logic bb_init;
		logic rf_cal;
		logic otp_copy;
		logic cal_all_chan;
		logic spi_on;
		logic retain_on;
		logic rtc_on;
	} pss_rails_t;

endpackage

/* hw/pss_sequencer.sv */
// power state sequencer: shutdown, sleep and active with ordered wake steps
// assumes pins are asynchronous; radio and firmware hints come from the core clock
// Contract
// - enable pin low forces Shutdown from any state
// - enable rising from Shutdown enters Active with Idle sub-state
// - host boots over serial port; boot completion enters Sleep
// - Sleep/Active moves never follow control pin levels or edges
// - device alone decides Active to Sleep
// - any host serial transaction in Sleep starts wake to Active
// - before association, sleep whenever no host work is pending; code also needs Idle sub-state and no radio request
// - after association, sleep when negotiated power save allows
// - wake steps: regulator, power, crystal, PLL, cores, baseband, RF
// - early steps fixed length; baseband and RF length depend on origin
// - from Shutdown full baseband init with factory config copy
// - from Shutdown full RF calibration; from Sleep operating channel only
// - crystal stopped in Sleep, runs during active operation
// - real-time clock runs in Sleep and drives wakeup timer
// - real-time clock calibrated at runtime against crystal reference
// - wakeup intervals measured from last beacon reference
// - crystal trim from non-volatile value, limited to 20 ppm
// - patch memory kept through Sleep
// - Sleep wakes on host activity or sleep timer expiry
// - Shutdown keeps nothing and reacts only to enable assertion
`timescale 1ns/1ns
module pss_sequencer
	import pss_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// pins
	input wire logic power_enable_pin,
	input wire logic host_sel_n_pin,
	input wire logic host_sck_pin,
	input wire logic rtc_clk_pin,
	// firmware and radio hints
	input wire logic host_work_pending,
	input wire logic radio_rx_req,
	input wire logic radio_tx_req,
	input wire logic boot_done,
	input wire logic associated,
	input wire logic ps_sleep_ok,
	input wire logic beacon_mark,
	input wire logic [15:0] wake_interval,
	input wire logic signed [7:0] otp_trim,
	// status and control out
	output pss_power_t power_state,
	output pss_sub_t active_sub,
	output pss_step_t wake_step,
	output pss_rails_t rails,
	output logic booted,
	output logic signed [7:0] xtal_trim,
	output logic [15:0] rtc_period
);

	typedef struct packed {
		pss_power_t pw;
		pss_sub_t sub;
		pss_step_t step;
		pss_rails_t rails;
		logic [11:0] step_cnt;
		logic from_shut;
		logic booted;
		logic [2:0] en_sy;
		logic [2:0] sel_sy;
		logic [2:0] sck_sy;
		logic [2:0] rtc_sy;
		logic en_filt;
		logic [4:0] filt_cnt;
		logic [15:0] since_beacon;
		logic [15:0] next_wake;
		logic [15:0] cal_cnt;
		logic [3:0] cal_ticks;
		logic [15:0] rtc_period;
		logic signed [7:0] trim;
	} pss_state_t;

	pss_state_t st;
	pss_state_t next_st;

	function automatic logic [11:0] step_len(input pss_step_t s, input logic full);
		unique case (s)
			STEP_REG: step_len = C_REG;
			STEP_PWR: step_len = C_PWR;
			STEP_XTAL: step_len = C_XTAL;
			STEP_PLL: step_len = C_PLL;
			STEP_CORE: step_len = C_CORE;
			STEP_BB: step_len = full ? C_BB_FULL : C_BB_WARM;
			STEP_RF: step_len = full ? C_RF_FULL : C_RF_WARM;
			default: step_len = 12'h001;
		endcase
	endfunction

	function automatic pss_step_t step_next(input pss_step_t s);
		unique case (s)
			STEP_REG: step_next = STEP_PWR;
			STEP_PWR: step_next = STEP_XTAL;
			STEP_XTAL: step_next = STEP_PLL;
			STEP_PLL: step_next = STEP_CORE;
			STEP_CORE: step_next = STEP_BB;
			STEP_BB: step_next = STEP_RF;
			default: step_next = STEP_DONE;
		endcase
	endfunction

	function automatic logic signed [7:0] clamp_trim(input logic signed [7:0] v);
		clamp_trim = (v > TRIM_MAX_PPM) ? TRIM_MAX_PPM : ((v < -TRIM_MAX_PPM) ? -TRIM_MAX_PPM : v);
	endfunction

	logic en_on;
	logic host_hit;
	logic rtc_tick;
	logic may_sleep;
	logic timer_due;

	always_comb begin
		next_st = st;
		// first stage feeds only the second
		next_st.en_sy = {st.en_sy[1:0], power_enable_pin};
		next_st.sel_sy = {st.sel_sy[1:0], host_sel_n_pin};
		next_st.sck_sy = {st.sck_sy[1:0], host_sck_pin};
		next_st.rtc_sy = {st.rtc_sy[1:0], rtc_clk_pin};

		// enable must hold a new level for the filter time
		if (st.en_sy[1] == st.en_filt) begin
			next_st.filt_cnt = 5'h00;
		end else if (st.filt_cnt == C_FILT - 5'h01) begin
			next_st.filt_cnt = 5'h00;
			next_st.en_filt = st.en_sy[1];
		end else begin
			next_st.filt_cnt = st.filt_cnt + 5'h01;
		end
		en_on = st.en_filt;

		// a rising clock edge while selected marks a host command
		host_hit = !st.sel_sy[1] && st.sck_sy[1] && !st.sck_sy[2];
		rtc_tick = st.rtc_sy[1] && !st.rtc_sy[2];

		// device-only sleep decision; no pin takes part
		if (associated) begin
			may_sleep = ps_sleep_ok && !host_work_pending;
		end else begin
			may_sleep = !host_work_pending;
		end
		timer_due = associated && (st.since_beacon >= st.next_wake);

		// wakeup timer counts from the last beacon, not the last wake
		if (st.pw != PSS_SHUTDOWN) begin
			if (beacon_mark && st.pw == PSS_ACTIVE) begin
				next_st.since_beacon = 16'h0000;
				next_st.next_wake = wake_interval;
			end else if (rtc_tick && st.since_beacon != 16'hFFFF) begin
				next_st.since_beacon = st.since_beacon + 16'h0001;
			end
		end

		// crystal cycles per CAL_TICKS rc ticks, only while crystal runs
		if (st.pw == PSS_ACTIVE && st.step == STEP_DONE) begin
			if (rtc_tick && st.cal_ticks == CAL_TICKS - 4'h1) begin
				next_st.rtc_period = st.cal_cnt;
				next_st.cal_cnt = 16'h0000;
				next_st.cal_ticks = 4'h0;
			end else begin
				if (st.cal_cnt != 16'hFFFF) begin
					next_st.cal_cnt = st.cal_cnt + 16'h0001;
				end
				if (rtc_tick) begin
					next_st.cal_ticks = st.cal_ticks + 4'h1;
				end
			end
		end else begin
			next_st.cal_cnt = 16'h0000;
			next_st.cal_ticks = 4'h0;
		end

		unique case (st.pw)
			PSS_SHUTDOWN: begin
				// only the enable wakes it; the serial port is unpowered here
				if (en_on) begin
					next_st.pw = PSS_ACTIVE;
					next_st.sub = SUB_IDLE;
					next_st.step = STEP_REG;
					next_st.step_cnt = 12'h000;
					next_st.from_shut = 1'b1;
					next_st.booted = 1'b0;
					next_st.trim = clamp_trim(otp_trim);
				end
			end
			PSS_SLEEP: begin
				if (host_hit || timer_due) begin
					next_st.pw = PSS_ACTIVE;
					next_st.sub = SUB_IDLE;
					next_st.step = STEP_REG;
					next_st.step_cnt = 12'h000;
					next_st.from_shut = 1'b0;
					if (timer_due) begin
						next_st.next_wake = st.next_wake + wake_interval;
					end
				end
			end
			PSS_ACTIVE: begin
				if (st.step != STEP_DONE) begin
					if (st.step_cnt == step_len(st.step, st.from_shut) - 12'h001) begin
						next_st.step = step_next(st.step);
						next_st.step_cnt = 12'h000;
					end else begin
						next_st.step_cnt = st.step_cnt + 12'h001;
					end
				end else if (!st.booted) begin
					if (boot_done) begin
						next_st.booted = 1'b1;
						next_st.pw = PSS_SLEEP;
					end
				end else begin
					if (radio_tx_req) begin
						next_st.sub = SUB_TX;
					end else if (radio_rx_req) begin
						next_st.sub = SUB_RX;
					end else begin
						next_st.sub = SUB_IDLE;
					end
					if (st.sub == SUB_IDLE && !radio_tx_req && !radio_rx_req && may_sleep) begin
						next_st.pw = PSS_SLEEP;
					end
				end
			end
		endcase

		if (!en_on) begin
			next_st.pw = PSS_SHUTDOWN;
			next_st.sub = SUB_IDLE;
			next_st.step = STEP_DONE;
			next_st.step_cnt = 12'h000;
			next_st.booted = 1'b0;
			next_st.since_beacon = 16'h0000;
			next_st.next_wake = RESET_WAKE;
			next_st.rtc_period = 16'h0000;
			next_st.trim = 8'sh00;
		end

		// rails follow the next state so each is a register
		next_st.rails = '0;
		if (next_st.pw != PSS_SHUTDOWN) begin
			next_st.rails.retain_on = 1'b1;
			next_st.rails.rtc_on = 1'b1;
			next_st.rails.spi_on = 1'b1;
		end
		if (next_st.pw == PSS_ACTIVE) begin
			next_st.rails.reg_high = 1'b1;
			next_st.rails.logic_on = next_st.step != STEP_REG;
			// crystal only when active, off through sleep
			next_st.rails.xtal_on = !(next_st.step inside {STEP_REG, STEP_PWR});
			next_st.rails.pll_on = next_st.step inside {STEP_PLL, STEP_CORE, STEP_BB, STEP_RF, STEP_DONE};
			next_st.rails.core_boot = next_st.step == STEP_CORE;
			next_st.rails.bb_init = next_st.step == STEP_BB;
			next_st.rails.otp_copy = next_st.step == STEP_BB && next_st.from_shut;
			next_st.rails.rf_cal = next_st.step == STEP_RF;
			next_st.rails.cal_all_chan = next_st.step == STEP_RF && next_st.from_shut;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st <= '0;
			st.pw <= PSS_SHUTDOWN;
			st.sub <= SUB_IDLE;
			st.step <= STEP_DONE;
			st.next_wake <= RESET_WAKE;
		end else begin
			st <= next_st;
		end
	end

	assign power_state = st.pw;
	assign active_sub = st.sub;
	assign wake_step = st.step;
	assign rails = st.rails;
	assign booted = st.booted;
	assign xtal_trim = st.trim;
	assign rtc_period = st.rtc_period;

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence s_shut_wake;
		st.pw == PSS_SHUTDOWN && st.en_filt;
	endsequence
	sequence s_into_active;
		st.pw == PSS_ACTIVE && st.sub == SUB_IDLE && st.step == STEP_REG;
	endsequence

	property p_shutdown_follows_enable;
		!st.en_filt |=> st.pw == PSS_SHUTDOWN && !rails.retain_on;
	endproperty
	a_shutdown_follows_enable: assert property (p_shutdown_follows_enable) else $error("enable low left device up");

	property p_enable_wakes_idle;
		s_shut_wake |=> s_into_active ##0 st.from_shut;
	endproperty
	a_enable_wakes_idle: assert property (p_enable_wakes_idle) else $error("enable did not enter active idle");

	property p_boot_to_sleep;
		st.pw == PSS_ACTIVE && st.step == STEP_DONE && !st.booted && boot_done && st.en_filt
			|=> st.pw == PSS_SLEEP && st.booted;
	endproperty
	a_boot_to_sleep: assert property (p_boot_to_sleep) else $error("boot finish did not enter sleep");

	property p_host_wakes;
		st.pw == PSS_SLEEP && st.en_filt && !st.sel_sy[1] && st.sck_sy[1] && !st.sck_sy[2]
			|=> s_into_active ##0 !st.from_shut;
	endproperty
	a_host_wakes: assert property (p_host_wakes) else $error("host command did not wake");

	property p_step_order;
		st.pw == PSS_ACTIVE && st.step == STEP_XTAL && $changed(st.step) && st.en_filt
			|-> $past(st.step) == STEP_PWR;
	endproperty
	a_step_order: assert property (p_step_order) else $error("crystal step out of order");

	logic [11:0] h_len;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			h_len <= 12'h000;
		end else if ($changed(st.step)) begin
			h_len <= 12'h001;
		end else begin
			h_len <= h_len + 12'h001;
		end
	end

	property p_reg_len;
		st.pw == PSS_ACTIVE && $past(st.step) == STEP_REG && st.step == STEP_PWR |-> h_len == C_REG;
	endproperty
	a_reg_len: assert property (p_reg_len) else $error("regulator step length wrong");

	property p_bb_len;
		st.pw == PSS_ACTIVE && $past(st.step) == STEP_BB && st.step == STEP_RF
			|-> h_len == ($past(st.from_shut) ? C_BB_FULL : C_BB_WARM);
	endproperty
	a_bb_len: assert property (p_bb_len) else $error("baseband step length wrong for origin");

	property p_otp_only_cold;
		rails.otp_copy |-> st.from_shut && st.step == STEP_BB;
	endproperty
	a_otp_only_cold: assert property (p_otp_only_cold) else $error("factory copy on warm wake");

	property p_full_cal_cold;
		rails.rf_cal |-> rails.cal_all_chan == st.from_shut;
	endproperty
	a_full_cal_cold: assert property (p_full_cal_cold) else $error("calibration depth wrong");

	property p_xtal_off_sleep;
		st.pw == PSS_SLEEP |-> !rails.xtal_on && rails.rtc_on && rails.retain_on;
	endproperty
	a_xtal_off_sleep: assert property (p_xtal_off_sleep) else $error("crystal on or retention off in sleep");

	property p_trim_range;
		xtal_trim <= TRIM_MAX_PPM && xtal_trim >= -TRIM_MAX_PPM;
	endproperty
	a_trim_range: assert property (p_trim_range) else $error("trim outside range");

	property p_filter;
		$rose(st.en_filt) |-> $past(st.en_sy[1], 2) && $past(st.en_sy[1], 1);
	endproperty
	a_filter: assert property (p_filter) else $error("enable passed without filtering");

endmodule

/* tb/pss_host_model.sv */
// host stand-in: drives the enable pin and frames serial commands
// assumes the sequencer samples these pins asynchronously to its clock
`timescale 1ns/1ns
module pss_host_model (
	// host pins
	output logic power_enable_pin,
	output logic host_sel_n_pin,
	output logic host_sck_pin
);
	initial begin
		power_enable_pin = 1'b0;
		host_sel_n_pin = 1'b1;
		host_sck_pin = 1'b0;
	end
	task automatic set_enable(input logic lvl);
		power_enable_pin = lvl;
	endtask
	// serial port is unpowered in shutdown, so no frame is sent then
	task automatic command(input int bits);
		if (power_enable_pin !== 1'b1)
			return;
		host_sel_n_pin = 1'b0;
		repeat (bits) begin
			#40 host_sck_pin = 1'b1;
			#40 host_sck_pin = 1'b0;
		end
		#40 host_sel_n_pin = 1'b1;
	endtask
	// edges with select released must never look like a command
	task automatic stray_clock(input int edges);
		repeat (edges) begin
			#40 host_sck_pin = ~host_sck_pin;
		end
	endtask
endmodule

/* tb/test_power_state_sequencer.sv */
// bench for the power state sequencer: cold boot, pin noise, host wake, timer wake, shutdown
// assumes the host stand-in module and the package step timing defaults
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
	$display("MISMATCH %0t got %h exp %h", $time, (a), (b)); end end
module test_power_state_sequencer
	import pss_pkg::*;
();
	logic clock;
	logic sys_rst;
	logic power_enable_pin;
	logic host_sel_n_pin;
	logic host_sck_pin;
	logic rtc_clk_pin;
	logic host_work_pending;
	logic radio_rx_req;
	logic radio_tx_req;
	logic boot_done;
	logic associated;
	logic ps_sleep_ok;
	logic beacon_mark;
	logic [15:0] wake_interval;
	logic signed [7:0] otp_trim;
	pss_power_t power_state;
	pss_sub_t active_sub;
	pss_step_t wake_step;
	pss_rails_t rails;
	logic booted;
	logic signed [7:0] xtal_trim;
	logic [15:0] rtc_period;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;

	pss_host_model host (.power_enable_pin(power_enable_pin), .host_sel_n_pin(host_sel_n_pin),
		.host_sck_pin(host_sck_pin));
	pss_sequencer uut (.clock(clock), .sys_rst(sys_rst), .power_enable_pin(power_enable_pin),
		.host_sel_n_pin(host_sel_n_pin), .host_sck_pin(host_sck_pin), .rtc_clk_pin(rtc_clk_pin),
		.host_work_pending(host_work_pending), .radio_rx_req(radio_rx_req), .radio_tx_req(radio_tx_req),
		.boot_done(boot_done), .associated(associated), .ps_sleep_ok(ps_sleep_ok),
		.beacon_mark(beacon_mark), .wake_interval(wake_interval), .otp_trim(otp_trim),
		.power_state(power_state), .active_sub(active_sub), .wake_step(wake_step), .rails(rails),
		.booted(booted), .xtal_trim(xtal_trim), .rtc_period(rtc_period));

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// rc clock of 125 ns, phase unrelated to the core clock
	initial begin
		rtc_clk_pin = 1'b0;
		#37;
		forever begin
			#62 rtc_clk_pin = 1'b1;
			#63 rtc_clk_pin = 1'b0;
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wait_state(input pss_power_t s, input int lim);
		int n = 0;
		while (power_state !== s && n < lim) begin
			cyc(1);
			n++;
		end
		`CHK(power_state, s)
	endtask
	// times every wake step from its first cycle
	task automatic wake_walk(input bit cold);
		int dur[7];
		int n;
		pss_step_t s;
		dur = '{250, 500, 3000, 1000, 2000, cold ? 3750 : 375, cold ? 4000 : 500};
		for (int i = 0; i < 7; i++) begin
			s = pss_step_t'(8'h01 << i);
			`CHK(wake_step, s)
			if (i == 5) `CHK(rails.otp_copy, cold)
			if (i == 6) `CHK(rails.cal_all_chan, cold)
			n = 0;
			while (wake_step === s && n < 5000) begin
				cyc(1);
				n++;
			end
			`CHK(n, dur[i])
		end
		`CHK(wake_step, STEP_DONE)
		`CHK(rails.xtal_on, 1'b1)
	endtask
	task automatic pulse_boot_beacon(input bit b, input bit m);
		boot_done = b;
		beacon_mark = m;
		cyc(1);
		boot_done = 1'b0;
		beacon_mark = 1'b0;
	endtask

	task automatic t_cold_boot();
		otp_trim = 8'sh30;
		host.set_enable(1'b1);
		wait_state(PSS_ACTIVE, 30);
		`CHK(active_sub, SUB_IDLE)
		wake_walk(1'b1);
		`CHK(xtal_trim, 8'sh14)
		cyc(20);
		`CHK(power_state, PSS_ACTIVE)
		pulse_boot_beacon(1'b1, 1'b0);
		wait_state(PSS_SLEEP, 5);
		`CHK(booted, 1'b1)
		`CHK(rails.xtal_on, 1'b0)
		`CHK(rails.rtc_on, 1'b1)
		`CHK(rails.retain_on, 1'b1)
		$display("test cold_boot done");
	endtask
	task automatic t_pins();
		host.stray_clock(8);
		cyc(1);
		host.set_enable(1'b0);
		cyc(8);
		host.set_enable(1'b1);
		cyc(40);
		`CHK(power_state, PSS_SLEEP)
		$display("test pins done");
	endtask
	task automatic t_host_wake();
		host_work_pending = 1'b1;
		fork
			host.command(8);
		join_none
		wait_state(PSS_ACTIVE, 120);
		wake_walk(1'b0);
		cyc(50);
		`CHK(power_state, PSS_ACTIVE)
		radio_rx_req = 1'b1;
		host_work_pending = 1'b0;
		cyc(20);
		`CHK(active_sub, SUB_RX)
		`CHK(power_state, PSS_ACTIVE)
		radio_tx_req = 1'b1;
		cyc(2);
		`CHK(active_sub, SUB_TX)
		`CHK(power_state, PSS_ACTIVE)
		radio_rx_req = 1'b0;
		radio_tx_req = 1'b0;
		wait_state(PSS_SLEEP, 10);
		$display("test host_wake done");
	endtask
	task automatic t_timer_wake();
		int n = 0;
		fork
			host.command(8);
		join_none
		wait_state(PSS_ACTIVE, 120);
		// associate only once awake, so the host command and not the timer did the wake
		associated = 1'b1;
		wake_interval = 16'h0006;
		wake_walk(1'b0);
		// first window starts mid-period; the second is a full eight ticks
		cyc(280);
		`CHK(power_state, PSS_ACTIVE)
		`CHK(rtc_period >= 16'h007C && rtc_period <= 16'h007E, 1'b1)
		pulse_boot_beacon(1'b0, 1'b1);
		ps_sleep_ok = 1'b1;
		wait_state(PSS_SLEEP, 10);
		while (power_state !== PSS_ACTIVE && n < 200) begin
			cyc(1);
			n++;
		end
		// six rc ticks of about 16 core cycles after the beacon
		`CHK(n > 70 && n < 104, 1'b1)
		associated = 1'b0;
		ps_sleep_ok = 1'b0;
		$display("test timer_wake done");
	endtask
	task automatic t_shutdown();
		host.set_enable(1'b0);
		wait_state(PSS_SHUTDOWN, 30);
		`CHK(rails, pss_rails_t'(12'h000))
		`CHK(booted, 1'b0)
		host.command(8);
		pulse_boot_beacon(1'b1, 1'b1);
		cyc(40);
		`CHK(power_state, PSS_SHUTDOWN)
		otp_trim = 8'shCE;
		host.set_enable(1'b1);
		wait_state(PSS_ACTIVE, 30);
		wake_walk(1'b1);
		`CHK(xtal_trim, 8'shEC)
		$display("test shutdown done");
	endtask

	task automatic close_out();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ceiling about twice the expected run
	always @(posedge clock) begin
		cycles++;
		if (cycles == 90000) begin
			mismatches++;
			close_out();
		end
	end

	initial begin
		sys_rst = 1'b1;
		host_work_pending = 1'b0;
		radio_rx_req = 1'b0;
		radio_tx_req = 1'b0;
		boot_done = 1'b0;
		associated = 1'b0;
		ps_sleep_ok = 1'b0;
		beacon_mark = 1'b0;
		wake_interval = 16'h0004;
		otp_trim = 8'sh00;
		cyc(6);
		sys_rst = 1'b0;
		`CHK(power_state, PSS_SHUTDOWN)
		`CHK(wake_step, STEP_DONE)
		t_cold_boot();
		t_pins();
		t_host_wake();
		t_timer_wake();
		t_shutdown();
		close_out();
	end
endmodule
